// ==== hdl/readout_pkg.sv ====
package readout_pkg;

    localparam int NUM_COLS = 1280;
    localparam int NUM_ROWS = 1024;
    localparam int COL_POS = NUM_COLS / 2;
    localparam int POS_W = 10;
    localparam int COL_W = 11;
    localparam int ROW_W = 10;
    localparam int PIX_W = 10;
    localparam int TRIM_W = 7;
    localparam int GAIN_W = 4;
    localparam int NOMINAL_W = 11;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_COL_START = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_ROW_START = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_GAIN = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_TRIM_COMMON = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_TRIM_PARITY = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_POSITION = 8'h1C;
    localparam logic [ADDR_W-1:0] OFF_GAIN_NOMINAL = 8'h20;

    localparam int CTRL_W = 6;
    localparam int CTRL_COL_SUB = 0;
    localparam int CTRL_COL_INNER = 1;
    localparam int CTRL_COL_OUTER = 2;
    localparam int CTRL_ROW_SUB = 3;
    localparam int CTRL_ROW_INNER = 4;
    localparam int CTRL_ROW_OUTER = 5;

    localparam int ST_COL_ACTIVE = 0;
    localparam int ST_ROW_ACTIVE = 1;
    localparam int ST_LINE_DONE = 2;
    localparam int ST_FRAME_DONE = 3;
    localparam int ST_LOADING = 4;

    localparam int POS_ROW_LSB = 16;

    localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
    localparam logic [POS_W-1:0] COL_START_RST = 10'h000;
    localparam logic [ROW_W-1:0] ROW_START_RST = 10'h000;
    localparam logic [GAIN_W-1:0] GAIN_RST = 4'h0;
    localparam logic [TRIM_W-1:0] TRIM_MID = 7'h40;

    typedef enum logic [1:0] {
        LINE_IDLE,
        LINE_LOAD,
        LINE_READ
    } line_state_type;

    // position of the read column or row within a group of four
    function automatic logic [1:0] sub_offset(input logic inner, input logic outer, input logic second);
        logic [1:0] first_off;
        logic [1:0] second_off;
        first_off = 2'h0;
        second_off = 2'h1;
        if (inner && outer) begin
            first_off = 2'h2;
            second_off = 2'h3;
        end else if (inner) begin
            second_off = 2'h2;
        end else if (outer) begin
            first_off = 2'h1;
            second_off = 2'h3;
        end
        return second ? second_off : first_off;
    endfunction : sub_offset

    // nominal dc gain times one hundred
    function automatic logic [NOMINAL_W-1:0] gain_x100(input logic [GAIN_W-1:0] code);
        logic [NOMINAL_W-1:0] g;
        case (code)
            4'h0: g = 11'd137;
            4'h1: g = 11'd162;
            4'h2: g = 11'd196;
            4'h3: g = 11'd233;
            4'h4: g = 11'd276;
            4'h5: g = 11'd350;
            4'h6: g = 11'd425;
            4'h7: g = 11'd520;
            4'h8: g = 11'd625;
            4'h9: g = 11'd789;
            4'hA: g = 11'd921;
            4'hB: g = 11'd1100;
            4'hC: g = 11'd1137;
            4'hD: g = 11'd1184;
            4'hE: g = 11'd1232;
            default: g = 11'd1242;
        endcase
        return g;
    endfunction : gain_x100

endpackage : readout_pkg

// ==== hdl/readout_pointer.sv ====
module readout_pointer #(
    parameter int NUM_POS = 640,
    parameter int IDX_W = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic step,
    input wire logic [1:0] amount,
    input wire logic [IDX_W-1:0] start_idx,
    output logic [IDX_W-1:0] index,
    output logic active
);

    logic [NUM_POS-1:0] onehot_r;
    logic [NUM_POS-1:0] decode;
    logic [IDX_W-1:0] index_r;

    genvar i;
    generate
        for (i = 0; i < NUM_POS; i++) begin : g_dec
            assign decode[i] = (start_idx == IDX_W'(i));
        end
    endgenerate

    // load wins over step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            onehot_r <= '0;
            index_r <= '0;
        end else if (load) begin
            onehot_r <= decode;
            index_r <= start_idx;
        end else if (step) begin
            onehot_r <= onehot_r << amount;
            index_r <= index_r + IDX_W'(amount);
        end
    end

    assign index = index_r;
    assign active = |onehot_r;

endmodule : readout_pointer

// ==== hdl/pixel_merge.sv ====
module pixel_merge #(
    parameter int PIX_W = 10,
    parameter int TRIM_W = 7
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic phase,
    input wire logic pair_valid,
    input wire logic [PIX_W-1:0] bus_a_signal,
    input wire logic [PIX_W-1:0] bus_a_reset,
    input wire logic [PIX_W-1:0] bus_b_signal,
    input wire logic [PIX_W-1:0] bus_b_reset,
    input wire logic [TRIM_W-1:0] trim_common,
    input wire logic [TRIM_W-1:0] trim_parity,
    output logic [PIX_W-1:0] pixel_data,
    output logic pixel_valid,
    output logic pixel_odd
);

    localparam int SW = PIX_W + 3;

    logic signed [SW-1:0] diff_a;
    logic signed [SW-1:0] diff_b;
    logic signed [SW-1:0] off_common;
    logic signed [SW-1:0] off_parity;
    logic signed [SW-1:0] val_a;
    logic signed [SW-1:0] val_b_r;
    logic valid_b_r;
    logic [PIX_W-1:0] pixel_r;
    logic valid_r;
    logic odd_r;

    function automatic logic [PIX_W-1:0] clamp(input logic signed [SW-1:0] v);
        logic [PIX_W-1:0] r;
        r = v[PIX_W-1:0];
        if (v < 0) begin
            r = '0;
        end else if (v > SW'((1 << PIX_W) - 1)) begin
            r = '1;
        end
        return r;
    endfunction : clamp

    // reset level minus pixel level cancels fixed pattern noise
    assign diff_a = SW'($signed({1'b0, bus_a_reset})) - SW'($signed({1'b0, bus_a_signal}));
    assign diff_b = SW'($signed({1'b0, bus_b_reset})) - SW'($signed({1'b0, bus_b_signal}));
    assign off_common = SW'($signed({1'b0, trim_common})) - SW'($signed({1'b0, readout_pkg::TRIM_MID}));
    assign off_parity = SW'($signed({1'b0, trim_parity})) - SW'($signed({1'b0, readout_pkg::TRIM_MID}));
    assign val_a = diff_a + off_common;

    // bus b held for the second cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            val_b_r <= '0;
            valid_b_r <= 1'b0;
            pixel_r <= '0;
            valid_r <= 1'b0;
            odd_r <= 1'b0;
        end else if (!phase) begin
            val_b_r <= diff_b + off_parity + off_common;
            valid_b_r <= pair_valid;
            pixel_r <= clamp(val_a);
            valid_r <= pair_valid;
            odd_r <= 1'b0;
        end else begin
            pixel_r <= clamp(val_b_r);
            valid_r <= valid_b_r;
            odd_r <= 1'b1;
        end
    end

    assign pixel_data = pixel_r;
    assign pixel_valid = valid_r;
    assign pixel_odd = odd_r;

endmodule : pixel_merge

// ==== hdl/pixel_readout.sv ====
// Operation
// - pointer position selects two columns, steps every second clock
// - even columns on bus a, odd on bus b unless column sub-sampling with one swap alone is set, merged to one stream per clock
// - start load puts a single one at the start position, zeros elsewhere
// - releasing start load lets the column pointer shift from the start
// - no column sub-sampling: one position per step
// - column sub-sampling moves two positions: two read, two skipped
// - inner swap exchanges columns 1 and 2 of each four, alternate reading
// - outer swap gives the alternate pattern starting with a skipped column
// - both swaps give two skipped then two read
// - no row sub-sampling: one row per step
// - with row sub-sampling two successive rows read, next two skipped
// - row swaps give the same patterns as column swaps
// - four-bit gain code on an exponential scale, lowest at zero
// - seven-bit offset codes drive a linear offset converter
// - separate parity trim between odd and even, common trim on both
// - pixel and reset levels both sampled; their difference cancels pattern noise
module pixel_readout #(
    parameter int NUM_COL_POS = readout_pkg::COL_POS,
    parameter int NUM_ROWS = readout_pkg::NUM_ROWS,
    parameter int PIX_W = readout_pkg::PIX_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [readout_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic col_start_load,
    input wire logic row_start_load,
    input wire logic row_step,
    input wire logic [PIX_W-1:0] bus_a_signal,
    input wire logic [PIX_W-1:0] bus_a_reset,
    input wire logic [PIX_W-1:0] bus_b_signal,
    input wire logic [PIX_W-1:0] bus_b_reset,
    output logic [readout_pkg::COL_W-1:0] bus_a_col,
    output logic [readout_pkg::COL_W-1:0] bus_b_col,
    output logic [readout_pkg::ROW_W-1:0] row_addr,
    output logic row_valid,
    output logic [PIX_W-1:0] pixel_data,
    output logic pixel_valid,
    output logic pixel_odd,
    output logic [readout_pkg::GAIN_W-1:0] amp_gain,
    output logic [readout_pkg::TRIM_W-1:0] offset_common,
    output logic [readout_pkg::TRIM_W-1:0] offset_parity
);

    localparam int POS_W = readout_pkg::POS_W;
    localparam int COL_W = readout_pkg::COL_W;
    localparam int ROW_W = readout_pkg::ROW_W;

    // register file
    logic [readout_pkg::CTRL_W-1:0] ctrl_r;
    logic [POS_W-1:0] col_start_r;
    logic [ROW_W-1:0] row_start_r;
    logic [readout_pkg::GAIN_W-1:0] gain_r;
    logic [readout_pkg::TRIM_W-1:0] trim_common_r;
    logic [readout_pkg::TRIM_W-1:0] trim_parity_r;
    logic line_done_r;
    logic frame_done_r;

    // bus slave
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic access;
    logic complete;
    logic wr_en;
    logic hit;
    logic [31:0] rd_mux;

    // column path
    logic col_sub;
    logic col_inner;
    logic col_outer;
    logic phase_r;
    logic col_step;
    logic [1:0] col_amount;
    logic [POS_W-1:0] col_pos;
    logic col_active;
    logic col_active_d_r;
    logic [COL_W-1:0] pair_base;
    logic [COL_W-1:0] group_base;
    logic [COL_W-1:0] col_a_nxt;
    logic [COL_W-1:0] col_b_nxt;
    logic [COL_W-1:0] bus_a_col_r;
    logic [COL_W-1:0] bus_b_col_r;

    // row path
    logic row_sub;
    logic row_inner;
    logic row_outer;
    logic [1:0] row_amount;
    logic [ROW_W-1:0] row_pos;
    logic row_active;
    logic row_active_d_r;
    logic [ROW_W-1:0] row_addr_nxt;
    logic [ROW_W-1:0] row_addr_r;
    logic row_valid_r;

    readout_pkg::line_state_type line_state_r;
    readout_pkg::line_state_type line_state_nxt;

    assign access = psel & penable;
    assign complete = access & pready_r;
    assign wr_en = complete & pwrite;

    assign col_sub = ctrl_r[readout_pkg::CTRL_COL_SUB];
    assign col_inner = ctrl_r[readout_pkg::CTRL_COL_INNER];
    assign col_outer = ctrl_r[readout_pkg::CTRL_COL_OUTER];
    assign row_sub = ctrl_r[readout_pkg::CTRL_ROW_SUB];
    assign row_inner = ctrl_r[readout_pkg::CTRL_ROW_INNER];
    assign row_outer = ctrl_r[readout_pkg::CTRL_ROW_OUTER];

    always_comb begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        if (paddr == readout_pkg::OFF_CTRL) begin
            rd_mux[readout_pkg::CTRL_W-1:0] = ctrl_r;
        end else if (paddr == readout_pkg::OFF_COL_START) begin
            rd_mux[POS_W-1:0] = col_start_r;
        end else if (paddr == readout_pkg::OFF_ROW_START) begin
            rd_mux[ROW_W-1:0] = row_start_r;
        end else if (paddr == readout_pkg::OFF_GAIN) begin
            rd_mux[readout_pkg::GAIN_W-1:0] = gain_r;
        end else if (paddr == readout_pkg::OFF_TRIM_COMMON) begin
            rd_mux[readout_pkg::TRIM_W-1:0] = trim_common_r;
        end else if (paddr == readout_pkg::OFF_TRIM_PARITY) begin
            rd_mux[readout_pkg::TRIM_W-1:0] = trim_parity_r;
        end else if (paddr == readout_pkg::OFF_STATUS) begin
            rd_mux[readout_pkg::ST_COL_ACTIVE] = col_active;
            rd_mux[readout_pkg::ST_ROW_ACTIVE] = row_active;
            rd_mux[readout_pkg::ST_LINE_DONE] = line_done_r;
            rd_mux[readout_pkg::ST_FRAME_DONE] = frame_done_r;
            rd_mux[readout_pkg::ST_LOADING] = (line_state_r == readout_pkg::LINE_LOAD);
        end else if (paddr == readout_pkg::OFF_POSITION) begin
            rd_mux[POS_W-1:0] = col_pos;
            rd_mux[readout_pkg::POS_ROW_LSB +: ROW_W] = row_pos;
        end else if (paddr == readout_pkg::OFF_GAIN_NOMINAL) begin
            rd_mux[readout_pkg::NOMINAL_W-1:0] = readout_pkg::gain_x100(gain_r);
        end else begin
            hit = 1'b0;
        end
    end

    // one wait state: answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= access & ~pready_r;
            pslverr_r <= access & ~pready_r & ~hit;
            prdata_r <= (access & ~pready_r & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= readout_pkg::CTRL_RST;
            col_start_r <= readout_pkg::COL_START_RST;
            row_start_r <= readout_pkg::ROW_START_RST;
            gain_r <= readout_pkg::GAIN_RST;
            trim_common_r <= readout_pkg::TRIM_MID;
            trim_parity_r <= readout_pkg::TRIM_MID;
        end else if (wr_en) begin
            if (paddr == readout_pkg::OFF_CTRL) begin
                ctrl_r <= pwdata[readout_pkg::CTRL_W-1:0];
            end else if (paddr == readout_pkg::OFF_COL_START) begin
                col_start_r <= pwdata[POS_W-1:0];
            end else if (paddr == readout_pkg::OFF_ROW_START) begin
                row_start_r <= pwdata[ROW_W-1:0];
            end else if (paddr == readout_pkg::OFF_GAIN) begin
                gain_r <= pwdata[readout_pkg::GAIN_W-1:0];
            end else if (paddr == readout_pkg::OFF_TRIM_COMMON) begin
                trim_common_r <= pwdata[readout_pkg::TRIM_W-1:0];
            end else if (paddr == readout_pkg::OFF_TRIM_PARITY) begin
                trim_parity_r <= pwdata[readout_pkg::TRIM_W-1:0];
            end
        end
    end

    // sticky end flags, write one to clear, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_done_r <= 1'b0;
            frame_done_r <= 1'b0;
        end else begin
            if (col_active_d_r & ~col_active & ~col_start_load) begin
                line_done_r <= 1'b1;
            end else if (wr_en && paddr == readout_pkg::OFF_STATUS && pwdata[readout_pkg::ST_LINE_DONE]) begin
                line_done_r <= 1'b0;
            end
            if (row_active_d_r & ~row_active & ~row_start_load) begin
                frame_done_r <= 1'b1;
            end else if (wr_en && paddr == readout_pkg::OFF_STATUS && pwdata[readout_pkg::ST_FRAME_DONE]) begin
                frame_done_r <= 1'b0;
            end
        end
    end

    // column pointer runs at half the clock rate
    assign col_step = phase_r & col_active & ~col_start_load;
    assign col_amount = col_sub ? 2'h2 : 2'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 1'b0;
        end else if (col_start_load) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    readout_pointer #(
        .NUM_POS(NUM_COL_POS),
        .IDX_W(POS_W)
    ) u_col_pointer (
        .pclk(pclk),
        .presetn(presetn),
        .load(col_start_load),
        .step(col_step),
        .amount(col_amount),
        .start_idx(col_start_r),
        .index(col_pos),
        .active(col_active)
    );

    // each position addresses a column pair; with sub-sampling, swaps reroute inside groups of four
    assign pair_base = {col_pos, 1'b0};
    assign group_base = {col_pos[POS_W-1:1], 2'b00};
    assign col_a_nxt = col_sub ? group_base + COL_W'(readout_pkg::sub_offset(col_inner, col_outer, 1'b0))
                               : pair_base;
    assign col_b_nxt = col_sub ? group_base + COL_W'(readout_pkg::sub_offset(col_inner, col_outer, 1'b1))
                               : pair_base + 11'h001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_a_col_r <= '0;
            bus_b_col_r <= '0;
            col_active_d_r <= 1'b0;
        end else begin
            bus_a_col_r <= col_a_nxt;
            bus_b_col_r <= col_b_nxt;
            col_active_d_r <= col_active;
        end
    end

    pixel_merge #(
        .PIX_W(PIX_W),
        .TRIM_W(readout_pkg::TRIM_W)
    ) u_merge (
        .pclk(pclk),
        .presetn(presetn),
        .phase(phase_r),
        .pair_valid(col_active & ~col_start_load),
        .bus_a_signal(bus_a_signal),
        .bus_a_reset(bus_a_reset),
        .bus_b_signal(bus_b_signal),
        .bus_b_reset(bus_b_reset),
        .trim_common(trim_common_r),
        .trim_parity(trim_parity_r),
        .pixel_data(pixel_data),
        .pixel_valid(pixel_valid),
        .pixel_odd(pixel_odd)
    );

    // row pointer: one row, or pairs of rows with two skipped
    assign row_amount = (row_sub && row_pos[0]) ? 2'h3 : 2'h1;

    readout_pointer #(
        .NUM_POS(NUM_ROWS),
        .IDX_W(ROW_W)
    ) u_row_pointer (
        .pclk(pclk),
        .presetn(presetn),
        .load(row_start_load),
        .step(row_step & row_active),
        .amount(row_amount),
        .start_idx(row_start_r),
        .index(row_pos),
        .active(row_active)
    );

    assign row_addr_nxt = row_sub ? {row_pos[ROW_W-1:2], readout_pkg::sub_offset(row_inner, row_outer, row_pos[0])}
                                  : row_pos;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            row_addr_r <= '0;
            row_valid_r <= 1'b0;
            row_active_d_r <= 1'b0;
        end else begin
            row_addr_r <= row_addr_nxt;
            row_valid_r <= row_active;
            row_active_d_r <= row_active;
        end
    end

    // line sequencing seen by software
    always_comb begin
        line_state_nxt = line_state_r;
        case (line_state_r)
            readout_pkg::LINE_IDLE: begin
                if (col_start_load) begin
                    line_state_nxt = readout_pkg::LINE_LOAD;
                end
            end
            readout_pkg::LINE_LOAD: begin
                if (!col_start_load) begin
                    line_state_nxt = readout_pkg::LINE_READ;
                end
            end
            readout_pkg::LINE_READ: begin
                if (col_start_load) begin
                    line_state_nxt = readout_pkg::LINE_LOAD;
                end else if (!col_active) begin
                    line_state_nxt = readout_pkg::LINE_IDLE;
                end
            end
            default: begin
                line_state_nxt = readout_pkg::LINE_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_state_r <= readout_pkg::LINE_IDLE;
        end else begin
            line_state_r <= line_state_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign bus_a_col = bus_a_col_r;
    assign bus_b_col = bus_b_col_r;
    assign row_addr = row_addr_r;
    assign row_valid = row_valid_r;
    assign amp_gain = gain_r;
    assign offset_common = trim_common_r;
    assign offset_parity = trim_parity_r;

endmodule : pixel_readout

// ==== dv/readout_checker_properties.sv ====
module readout_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic col_start_load,
    input wire logic [10:0] bus_a_col,
    input wire logic pixel_valid,
    input wire logic pixel_odd,
    input wire logic [3:0] amp_gain,
    input wire logic [6:0] offset_common
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pready && pwrite;
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready) else $error("bad wait");
    err_answer_a: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
    unmapped_err_a: assert property (psel && penable && pready && paddr > 8'h20 |-> pslverr) else $error("no error");
    gain_write_a: assert property (wr && paddr == 8'h0C |=> amp_gain == $past(pwdata[3:0])) else $error("gain");
    gain_hold_a: assert property ($changed(amp_gain) |-> $past(wr) && $past(paddr) == 8'h0C) else $error("gain");
    trim_write_a: assert property (wr && paddr == 8'h10 |=> offset_common == $past(pwdata[6:0])) else $error("trim");
    col_half_a: assert property ($changed(bus_a_col) && !col_start_load |=> $stable(bus_a_col)) else $error("col");
    odd_next_a: assert property (pixel_valid && !pixel_odd |=> pixel_valid && pixel_odd) else $error("odd");
    cover property (wr && paddr == 8'h0C);
    cover property (pslverr);
    cover property (pixel_valid && pixel_odd);
endmodule : readout_checker

bind pixel_readout readout_checker chk_u (.*);

// ==== dv/camera_ctrl_model.sv ====
module camera_ctrl_model (
    input wire logic pclk,
    output logic col_start_load = 1'b0,
    output logic row_start_load = 1'b0,
    output logic row_step = 1'b0,
    output logic [9:0] a_sig = 10'h000,
    output logic [9:0] a_rst = 10'h000,
    output logic [9:0] b_sig = 10'h000,
    output logic [9:0] b_rst = 10'h000
);
    timeunit 1ns;
    timeprecision 1ps;
    // start load held over several edges
    task automatic load_columns(input int hold);
        col_start_load <= 1'b1;
        repeat (hold) @(posedge pclk);
        col_start_load <= 1'b0;
    endtask : load_columns
    task automatic pulse_row(input logic start);
        row_start_load <= start;
        row_step <= !start;
        @(posedge pclk);
        row_start_load <= 1'b0;
        row_step <= 1'b0;
        @(posedge pclk);
    endtask : pulse_row
    task automatic set_levels(input logic [15:0] s0, s1, s2, s3);
        a_sig <= s0[9:0];
        a_rst <= s1[9:0];
        b_sig <= s2[9:0];
        b_rst <= s3[9:0];
        @(posedge pclk);
    endtask : set_levels
endmodule : camera_ctrl_model

// ==== dv/pixel_readout_tb.sv ====
module pixel_readout_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, col_start_load, row_start_load, row_step, row_valid, pixel_valid, pixel_odd, e;
    logic [9:0] a_sig, a_rst, b_sig, b_rst, row_addr, pixel_data;
    logic [10:0] a_col, b_col;
    logic [3:0] amp_gain;
    logic [6:0] off_c, off_p;
    logic [15:0] seed = 16'h4BE4;
    int err_count = 0;
    int comparisons = 0;
    int ctrl_t[5] = '{0, 1, 3, 5, 7};
    int lo_t[5] = '{0, 0, 0, 1, 2};
    int hi_t[5] = '{1, 1, 2, 3, 3};
    pixel_readout dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .col_start_load(col_start_load), .row_start_load(row_start_load), .row_step(row_step),
        .bus_a_signal(a_sig), .bus_a_reset(a_rst), .bus_b_signal(b_sig), .bus_b_reset(b_rst),
        .bus_a_col(a_col), .bus_b_col(b_col), .row_addr(row_addr), .row_valid(row_valid),
        .pixel_data(pixel_data), .pixel_valid(pixel_valid), .pixel_odd(pixel_odd), .amp_gain(amp_gain),
        .offset_common(off_c), .offset_parity(off_p));
    camera_ctrl_model ctrl_u (.pclk(pclk), .col_start_load(col_start_load), .row_start_load(row_start_load),
        .row_step(row_step), .a_sig(a_sig), .a_rst(a_rst), .b_sig(b_sig), .b_rst(b_rst));
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction : rnd
    function automatic logic [31:0] pix(input logic [9:0] s, input logic [9:0] r, input int t);
        int v;
        v = int'(r) - int'(s) + t;
        return (v < 0) ? 32'h0 : (v > 1023) ? 32'h3FF : v;
    endfunction : pix
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, exp, got);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    initial begin
        forever #10 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        test_done();
    end
    initial begin
        int k, m, p, n, tc, tp, g, b;
        logic [10:0] la;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check("reset out", 32'h4040, {amp_gain, off_c, 1'b0, off_p});
        for (k = 0; k < 4; k++) begin
            g = (k == 3) ? 15 : rnd() % 16;
            tc = rnd() % 128;
            tp = rnd() % 128;
            apb(1'b1, readout_pkg::OFF_GAIN, g);
            apb(1'b1, readout_pkg::OFF_TRIM_COMMON, tc);
            apb(1'b1, readout_pkg::OFF_TRIM_PARITY, tp);
            apb(1'b0, readout_pkg::OFF_GAIN, 32'h0);
            check("gain", {g[3:0], g[3:0]}, {q[3:0], amp_gain});
            check("trims", {tc[6:0], tp[6:0]}, {off_c, off_p});
        end
        apb(1'b0, readout_pkg::OFF_GAIN_NOMINAL, 32'h0);
        check("nominal", 32'h4DA, q);
        apb(1'b1, 8'h3C, 32'h0);
        check("bad wr", {1'b1, g[3:0]}, {e, amp_gain});
        apb(1'b0, 8'h24, 32'h0);
        check("bad rd", 1, e);
        $display("registers test done");
        for (m = 0; m < 5; m++) begin
            apb(1'b1, readout_pkg::OFF_CTRL, ctrl_t[m] << 3);
            apb(1'b1, readout_pkg::OFF_ROW_START, 32'h0);
            ctrl_u.pulse_row(1'b1);
            for (k = 0; k < 6; k++) begin
                @(posedge pclk);
                b = (m == 0) ? k : 4 * (k / 2) + ((k % 2) ? hi_t[m] : lo_t[m]);
                check("row", b + 1024, {row_valid, row_addr});
                ctrl_u.pulse_row(1'b0);
            end
        end
        $display("rows test done");
        for (m = 0; m < 5; m++) begin
            p = (rnd() % 160) * 2;
            apb(1'b1, readout_pkg::OFF_CTRL, ctrl_t[m]);
            apb(1'b1, readout_pkg::OFF_COL_START, p);
            ctrl_u.set_levels(rnd(), rnd(), rnd(), rnd());
            ctrl_u.load_columns(3);
            la = 11'h7FF;
            n = 0;
            k = 0;
            while (k < 4 && n < 40) begin
                @(posedge pclk);
                n++;
                if (pixel_valid === 1'b1) begin
                    check("pixel", pixel_odd ? pix(b_sig, b_rst, tc + tp - 128) : pix(a_sig, a_rst, tc - 64),
                        pixel_data);
                end
                if (a_col !== la) begin
                    b = (m == 0) ? 2 * (p + k) : 4 * (p / 2 + k);
                    check("col lo", b + lo_t[m], a_col);
                    check("col hi", b + hi_t[m], b_col);
                    la = a_col;
                    k++;
                end
            end
            check("col steps", 4, k);
            wait (pixel_valid === 1'b0);
        end
        $display("columns test done");
        test_done();
    end
endmodule : pixel_readout_tb
